// ==== verilog/dhp_pkg.sv ====
// Shared constants and types for the decompressor host and transfer ports
package dhp_pkg;
	// Widths of the register port and the transfer bus
	localparam int REG_W = 8;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;

	// Register offsets on the register index bus
	localparam logic [5:0] OFF_SYS_CFG1 = 6'h01;
	localparam logic [5:0] OFF_DEC_CTRL = 6'h18;
	localparam logic [5:0] OFF_INT_STAT = 6'h27;
	localparam logic [5:0] OFF_INT_MASK = 6'h29;
	localparam logic [5:0] OFF_NEXT_CTRL = 6'h38;
	localparam logic [5:0] OFF_UNLOCK = 6'h3f;

	// Reset values, and the unlock code that enables the engine run
	localparam logic [7:0] RST_SYS_CFG1 = 8'h00;
	localparam logic [7:0] RST_DEC_CTRL = 8'h04;
	localparam logic [7:0] RST_INT_STAT = 8'h00;
	localparam logic [7:0] RST_INT_MASK = 8'hff;
	localparam logic [7:0] RST_NEXT_CTRL = 8'h00;
	localparam logic [7:0] RST_UNLOCK = 8'h0f;
	localparam logic [7:0] UNLOCK_GOOD = 8'h0e;

	// Decompression control bit positions, shared by active and staged copies
	localparam int BIT_STAGE_LOAD = 7;
	localparam int BIT_BLANK = 6;
	localparam int BIT_POT = 5;
	localparam int BIT_PASS = 4;
	localparam int BIT_DICT_RST = 3;
	localparam int BIT_EMPTY = 2;
	localparam int BIT_RUN = 1;
	localparam int BIT_POR = 0;

	// Interrupt status bit and configuration fields
	localparam int BIT_EOT_INT = 1;
	localparam logic [7:0] INT_USED = 8'h02;
	localparam int STROBE_LSB = 0;
	localparam int BIT_WIDE = 2;

	// Strobe conditions held in configuration register 1, bits 1:0
	typedef enum logic [1:0] {STROBE_ACK_ONLY, STROBE_WAIT_HIGH, STROBE_WAIT_LOW, STROBE_SPARE} dhp_strobe_type;

	// Register port sequencer states
	typedef enum logic [1:0] {PORT_IDLE, PORT_ACCESS, PORT_READY} dhp_port_state_type;
endpackage : dhp_pkg

// ==== verilog/dhp_sync3.sv ====
// Three-stage synchroniser for an asynchronous level pin
`timescale 1ns/10ps
module dhp_sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin and synchronised level
	input wire logic pin_in,
	output logic level_ff
);
	logic meta_ff;
	logic s2_ff;
	logic s3_ff;

	// First stage feeds only the second; output moves when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			level_ff <= 1'b1;
		end
		else
		begin
			meta_ff <= pin_in;
			s2_ff <= meta_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				level_ff <= s3_ff;
		end
	end
endmodule : dhp_sync3

// ==== verilog/dhp_skid_buf.sv ====
// Two-entry buffer with registered outputs on both sides
`timescale 1ns/10ps
module dhp_skid_buf (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic [dhp_pkg::DATA_W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic full_ff,
	// Draining side
	output logic [dhp_pkg::DATA_W-1:0] head_ff,
	output logic head_valid_ff,
	input wire logic out_ready
);
	logic [dhp_pkg::DATA_W-1:0] tail_ff;
	wire push = in_valid & ~full_ff;
	wire pop = head_valid_ff & out_ready;

	assign in_ready = ~full_ff;

	// Head refills from the tail first so word order is kept
	always_ff @(posedge clk)
	begin
		if (rst)
			head_valid_ff <= 1'b0;
		else if (!head_valid_ff || pop)
			head_valid_ff <= full_ff | push;
	end

	always_ff @(posedge clk)
	begin
		if (!head_valid_ff || pop)
			head_ff <= full_ff ? tail_ff : in_data;
	end

	// Tail catches a word only when the head is held by a stalled reader
	always_ff @(posedge clk)
	begin
		if (rst)
			full_ff <= 1'b0;
		else if (full_ff)
			full_ff <= ~pop;
		else
			full_ff <= push & head_valid_ff & ~pop;
	end

	always_ff @(posedge clk)
	begin
		if (push && head_valid_ff && !pop)
			tail_ff <= in_data;
	end
endmodule : dhp_skid_buf

// ==== verilog/dhp_host_ports.sv ====
// Register port, transfer bus ports and staged decompression control
`timescale 1ns/10ps
module dhp_host_ports (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [dhp_pkg::ADDR_W-1:0] register_index_bus,
	input wire logic [dhp_pkg::REG_W-1:0] register_byte_in,
	output logic [dhp_pkg::REG_W-1:0] register_byte_out,
	output logic register_byte_oe_n,
	input wire logic chip_select_n,
	input wire logic direction,
	input wire logic [1:0] host_port_config,
	output logic access_ready_n,
	output logic interrupt_n,
	// Transfer bus
	input wire logic [dhp_pkg::DATA_W-1:0] data_in,
	output logic [dhp_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic bus_output_enable_n,
	input wire logic strobe_wait_insert,
	output logic input_port_request_n,
	input wire logic input_port_ack_n,
	output logic output_port_request_n,
	input wire logic output_port_ack_n,
	// Engine side
	output logic [dhp_pkg::DATA_W-1:0] engine_in_data,
	output logic engine_in_valid,
	input wire logic engine_in_ready,
	input wire logic [dhp_pkg::DATA_W-1:0] engine_out_data,
	input wire logic engine_out_valid,
	output logic engine_out_ready,
	input wire logic engine_eor,
	input wire logic engine_eot,
	input wire logic engine_empty_flag,
	output logic [dhp_pkg::REG_W-1:0] decomp_control,
	output logic engine_run_enable
);
	// Register state
	logic [7:0] next_decomp_control_ff;
	logic [7:0] operation_unlock_code_ff;
	logic [7:0] sys_cfg1_ff;
	logic [7:0] int_stat_ff;
	logic [7:0] int_mask_ff;
	logic [7:0] ctrl_ff;
	dhp_pkg::dhp_port_state_type state_ff;
	dhp_pkg::dhp_port_state_type nxt_state;
	logic [5:0] addr_ff;
	logic [7:0] wdata_ff;
	logic is_read_ff;
	logic engine_empty_ff;
	logic out_have_ff;
	logic drive_en_n_sync;
	logic in_full_ff;
	logic buf_in_ready;

	// Register port decode
	wire access = (state_ff == dhp_pkg::PORT_ACCESS);
	wire wr = access & ~is_read_ff;
	wire wr_next = wr && (addr_ff == dhp_pkg::OFF_NEXT_CTRL);
	wire wr_ctrl = wr && (addr_ff == dhp_pkg::OFF_DEC_CTRL);
	wire wr_code = wr && (addr_ff == dhp_pkg::OFF_UNLOCK);
	wire wr_cfg1 = wr && (addr_ff == dhp_pkg::OFF_SYS_CFG1);
	wire wr_stat = wr && (addr_ff == dhp_pkg::OFF_INT_STAT);
	wire wr_mask = wr && (addr_ff == dhp_pkg::OFF_INT_MASK);
	wire dir_is_read = direction ^ host_port_config[0];
	wire hold_ready = host_port_config[1];
	wire stage_xfer = ctrl_ff[dhp_pkg::BIT_STAGE_LOAD] & engine_eor;
	wire [7:0] ctrl_view = {ctrl_ff[7:3], engine_empty_ff, ctrl_ff[1:0]};
	wire [7:0] int_set = {6'h00, engine_eot, 1'b0} & dhp_pkg::INT_USED;

	// Read data selection
	wire [7:0] rdata =
		(addr_ff == dhp_pkg::OFF_NEXT_CTRL) ? next_decomp_control_ff :
		(addr_ff == dhp_pkg::OFF_UNLOCK) ? operation_unlock_code_ff :
		(addr_ff == dhp_pkg::OFF_DEC_CTRL) ? ctrl_view :
		(addr_ff == dhp_pkg::OFF_SYS_CFG1) ? sys_cfg1_ff :
		(addr_ff == dhp_pkg::OFF_INT_STAT) ? int_stat_ff :
		(addr_ff == dhp_pkg::OFF_INT_MASK) ? int_mask_ff : 8'h00;

	// Strobe condition: strobe delay unused, waits while high, or waits while low
	wire [1:0] strobe_sel = sys_cfg1_ff[dhp_pkg::STROBE_LSB +: 2];
	wire strobe_ok = (strobe_sel == dhp_pkg::STROBE_WAIT_HIGH) ? ~strobe_wait_insert :
		(strobe_sel == dhp_pkg::STROBE_WAIT_LOW) ? strobe_wait_insert : 1'b1;
	wire wide = sys_cfg1_ff[dhp_pkg::BIT_WIDE];
	wire in_push = ~input_port_ack_n & strobe_ok;
	wire [31:0] in_word = wide ? data_in : {16'h0000, data_in[15:0]};
	wire out_pop = out_have_ff & ~output_port_ack_n & strobe_ok;
	wire out_take = engine_out_valid & engine_out_ready;
	wire nxt_have = (out_have_ff & ~out_pop) | out_take;
	wire drive_now = ~drive_en_n_sync & ~output_port_ack_n & strobe_ok & out_have_ff;

	// Register port sequencer: capture on chip select, act, then answer
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			dhp_pkg::PORT_IDLE: if (!chip_select_n) nxt_state = dhp_pkg::PORT_ACCESS;
			dhp_pkg::PORT_ACCESS: nxt_state = dhp_pkg::PORT_READY;
			dhp_pkg::PORT_READY: if (!hold_ready || chip_select_n) nxt_state = dhp_pkg::PORT_IDLE;
			default: nxt_state = dhp_pkg::PORT_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_ff <= dhp_pkg::PORT_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Access capture: index, data and direction are sampled with chip select
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			addr_ff <= 6'h00;
			wdata_ff <= 8'h00;
			is_read_ff <= 1'b0;
		end
		else if (state_ff == dhp_pkg::PORT_IDLE && !chip_select_n)
		begin
			addr_ff <= register_index_bus;
			wdata_ff <= register_byte_in;
			is_read_ff <= dir_is_read;
		end
	end

	// Ready and read data drive on the byte bus
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			access_ready_n <= 1'b1;
			register_byte_oe_n <= 1'b1;
			register_byte_out <= 8'h00;
		end
		else
		begin
			access_ready_n <= ~(nxt_state == dhp_pkg::PORT_READY);
			register_byte_oe_n <= ~((nxt_state == dhp_pkg::PORT_READY) && is_read_ff);
			if (access && is_read_ff)
				register_byte_out <= rdata;
		end
	end

	// Staged control copy; the transfer clears it and beats a same-cycle write
	always_ff @(posedge clk)
	begin
		if (rst)
			next_decomp_control_ff <= dhp_pkg::RST_NEXT_CTRL;
		else if (stage_xfer)
			next_decomp_control_ff <= 8'h00;
		else if (wr_next)
			next_decomp_control_ff <= wdata_ff;
	end

	// Active control; bit 2 is stored, but reads and the decomp_control output show the live empty flag in its place
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl_ff <= dhp_pkg::RST_DEC_CTRL;
		else if (stage_xfer)
			ctrl_ff <= next_decomp_control_ff;
		else if (wr_ctrl)
			ctrl_ff <= wdata_ff;
	end

	// Unlock code, configuration and mask registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			operation_unlock_code_ff <= dhp_pkg::RST_UNLOCK;
			sys_cfg1_ff <= dhp_pkg::RST_SYS_CFG1;
			int_mask_ff <= dhp_pkg::RST_INT_MASK;
		end
		else
		begin
			if (wr_code)
				operation_unlock_code_ff <= wdata_ff;
			if (wr_cfg1)
				sys_cfg1_ff <= wdata_ff;
			if (wr_mask)
				int_mask_ff <= wdata_ff;
		end
	end

	// Sticky interrupt status, write one to clear, a new event wins
	always_ff @(posedge clk)
	begin
		if (rst)
			int_stat_ff <= dhp_pkg::RST_INT_STAT;
		else
			int_stat_ff <= ((wr_stat ? (int_stat_ff & ~wdata_ff) : int_stat_ff) | int_set) & dhp_pkg::INT_USED;
	end

	// Interrupt pin and engine-facing control outputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			interrupt_n <= 1'b1;
			engine_empty_ff <= 1'b1;
			decomp_control <= dhp_pkg::RST_DEC_CTRL;
			engine_run_enable <= 1'b0;
		end
		else
		begin
			interrupt_n <= ~|(int_stat_ff & ~int_mask_ff);
			engine_empty_ff <= engine_empty_flag;
			decomp_control <= ctrl_view;
			engine_run_enable <= ctrl_ff[dhp_pkg::BIT_RUN] & (operation_unlock_code_ff == dhp_pkg::UNLOCK_GOOD);
		end
	end

	// Drive enable pin is asynchronous
	dhp_sync3 dhp_sync3_i (
		.clk(clk),
		.rst(rst),
		.pin_in(bus_output_enable_n),
		.level_ff(drive_en_n_sync)
	);

	// Input port buffer; its full flag is the input request pin
	dhp_skid_buf dhp_skid_buf_i (
		.clk(clk),
		.rst(rst),
		.in_data(in_word),
		.in_valid(in_push),
		.in_ready(buf_in_ready),
		.full_ff(in_full_ff),
		.head_ff(engine_in_data),
		.head_valid_ff(engine_in_valid),
		.out_ready(engine_in_ready)
	);
	assign input_port_request_n = in_full_ff;

	// Output port holding register and bus drive
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			out_have_ff <= 1'b0;
			output_port_request_n <= 1'b1;
			engine_out_ready <= 1'b1;
			data_oe_n <= 1'b1;
			data_out <= 32'h00000000;
		end
		else
		begin
			out_have_ff <= nxt_have;
			output_port_request_n <= ~nxt_have;
			engine_out_ready <= ~nxt_have;
			data_oe_n <= ~drive_now;
			if (out_take)
				data_out <= wide ? engine_out_data : {16'hffff, engine_out_data[15:0]};
		end
	end

	// Checks
	property p_stage_reset;
		@(posedge clk) disable iff (rst) $fell(rst) |-> next_decomp_control_ff == 8'h00;
	endproperty
	a_stage_reset: assert property (p_stage_reset) else $error("staged control not zero after reset");

	property p_stage_xfer;
		@(posedge clk) disable iff (rst) stage_xfer |=> next_decomp_control_ff == 8'h00 && ctrl_ff == $past(next_decomp_control_ff);
	endproperty
	a_stage_xfer: assert property (p_stage_xfer) else $error("staged transfer wrong");

	property p_code_reset;
		@(posedge clk) disable iff (rst) $fell(rst) |-> operation_unlock_code_ff == 8'h0f;
	endproperty
	a_code_reset: assert property (p_code_reset) else $error("unlock code not 0x0f after reset");

	property p_cs_ready;
		@(posedge clk) disable iff (rst) (state_ff == dhp_pkg::PORT_IDLE && !chip_select_n) |-> ##2 !access_ready_n;
	endproperty
	a_cs_ready: assert property (p_cs_ready) else $error("ready not two cycles after select");

	property p_read_back;
		@(posedge clk) disable iff (rst) (access && is_read_ff && addr_ff == dhp_pkg::OFF_NEXT_CTRL && !stage_xfer)
			|=> !register_byte_oe_n && register_byte_out == next_decomp_control_ff;
	endproperty
	a_read_back: assert property (p_read_back) else $error("staged read-back mismatch");

	property p_dir_pol;
		@(posedge clk) disable iff (rst) (state_ff == dhp_pkg::PORT_IDLE && !chip_select_n)
			|=> is_read_ff == ($past(direction) ^ $past(host_port_config[0]));
	endproperty
	a_dir_pol: assert property (p_dir_pol) else $error("direction polarity wrong");

	property p_irq;
		@(posedge clk) disable iff (rst) ##1 (interrupt_n == ~|($past(int_stat_ff) & ~$past(int_mask_ff)));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt pin disagrees with status");

	property p_capture;
		@(posedge clk) disable iff (rst) (in_push && buf_in_ready && !engine_in_valid)
			|=> engine_in_valid && engine_in_data == $past(in_word);
	endproperty
	a_capture: assert property (p_capture) else $error("input word not captured");

	property p_drive;
		@(posedge clk) disable iff (rst) !data_oe_n |-> $past(!drive_en_n_sync && !output_port_ack_n && out_have_ff);
	endproperty
	a_drive: assert property (p_drive) else $error("bus bus_output_enable_n without enable");

	property p_out_req;
		@(posedge clk) disable iff (rst) (out_take || (!output_port_request_n && output_port_ack_n))
			|=> !output_port_request_n;
	endproperty
	a_out_req: assert property (p_out_req) else $error("output request disagrees with held word");

	property p_empty_view;
		@(posedge clk) disable iff (rst) (access && is_read_ff && addr_ff == dhp_pkg::OFF_DEC_CTRL)
			|=> register_byte_out[2] == $past(engine_empty_ff);
	endproperty
	a_empty_view: assert property (p_empty_view) else $error("empty flag read wrong");
endmodule : dhp_host_ports

// ==== testbench/dhp_dma_model.sv ====
// Behavioural DMA controller facing the shared transfer bus
`timescale 1ns/10ps
module dhp_dma_model (
	// Clock and mirrored bus configuration
	input wire logic clk,
	input wire logic [1:0] strobe_mode,
	input wire logic wide,
	// Transfer bus
	input wire logic [31:0] data_out,
	input wire logic data_oe_n,
	output logic [31:0] data_in,
	output logic bus_output_enable_n,
	output logic strobe_wait_insert,
	// Request and acknowledge pairs
	input wire logic input_port_request_n,
	output logic input_port_ack_n,
	input wire logic output_port_request_n,
	output logic output_port_ack_n
);
	logic timed_out, oe_seen;
	int n;
	// Pin level that meets or blocks the programmed strobe condition
	function automatic logic sd_level(input logic ok);
		return (strobe_mode == 2'h2) ? ok : ~ok;
	endfunction : sd_level
	// Idle bus with the upper half pulled up
	initial
	begin
		timed_out = 1'b0;
		oe_seen = 1'b0;
		data_in = 32'hffffffff;
		bus_output_enable_n = 1'b1;
		strobe_wait_insert = 1'b0;
		input_port_ack_n = 1'b1;
		output_port_ack_n = 1'b1;
	end
	// Hold word and acknowledge through the wait states until the device takes it
	task automatic send_word(input logic [31:0] w, input int waits);
		@(negedge clk);
		data_in = wide ? w : {16'hffff, w[15:0]};
		input_port_ack_n = 1'b0;
		strobe_wait_insert = sd_level(waits == 0);
		n = 0;
		while ((n < waits || input_port_request_n) && n < 64)
		begin
			@(negedge clk);
			n++;
			strobe_wait_insert = sd_level(n >= waits);
		end
		timed_out |= (n >= 64);
		@(negedge clk);
		input_port_ack_n = 1'b1;
		data_in = {wide ? ~data_in[31:16] : 16'hffff, ~data_in[15:0]};
		strobe_wait_insert = sd_level(1'b0);
	endtask : send_word
	// Pop one word from the output port with drive enable low
	task automatic take_word(output logic [31:0] w);
		@(negedge clk);
		bus_output_enable_n = 1'b0;
		repeat (5) @(negedge clk);
		output_port_ack_n = 1'b0;
		strobe_wait_insert = sd_level(1'b1);
		n = 0;
		while (output_port_request_n && n < 64)
		begin
			@(negedge clk);
			n++;
		end
		timed_out |= (n >= 64);
		w = data_out;
		@(negedge clk);
		oe_seen = ~data_oe_n;
		output_port_ack_n = 1'b1;
		bus_output_enable_n = 1'b1;
		strobe_wait_insert = sd_level(1'b0);
	endtask : take_word
endmodule : dhp_dma_model

// ==== testbench/dhp_host_ports_test.sv ====
// Self-checking bench for the decompressor host and transfer ports
`timescale 1ns/10ps
module dhp_host_ports_test;
	logic clk, rst, register_byte_oe_n, chip_select_n, direction, access_ready_n, interrupt_n, data_oe_n;
	logic bus_output_enable_n, strobe_wait_insert, input_port_request_n, input_port_ack_n, output_port_request_n;
	logic output_port_ack_n, engine_in_valid, engine_in_ready, engine_out_valid, engine_out_ready, engine_eor;
	logic engine_eot, engine_empty_flag, engine_run_enable, wide;
	logic [1:0] host_port_config, strobe_mode;
	logic [5:0] register_index_bus;
	logic [7:0] register_byte_in, register_byte_out, decomp_control;
	logic [31:0] data_in, data_out, engine_in_data, engine_out_data, w;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	// Device and far-side DMA model
	dhp_host_ports dhp_host_ports_i (.clk(clk), .rst(rst), .register_index_bus(register_index_bus),
		.register_byte_in(register_byte_in), .register_byte_out(register_byte_out),
		.register_byte_oe_n(register_byte_oe_n), .chip_select_n(chip_select_n), .direction(direction),
		.host_port_config(host_port_config), .access_ready_n(access_ready_n), .interrupt_n(interrupt_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .bus_output_enable_n(bus_output_enable_n),
		.strobe_wait_insert(strobe_wait_insert), .input_port_request_n(input_port_request_n),
		.input_port_ack_n(input_port_ack_n), .output_port_request_n(output_port_request_n),
		.output_port_ack_n(output_port_ack_n), .engine_in_data(engine_in_data), .engine_in_valid(engine_in_valid),
		.engine_in_ready(engine_in_ready), .engine_out_data(engine_out_data), .engine_out_valid(engine_out_valid),
		.engine_out_ready(engine_out_ready), .engine_eor(engine_eor), .engine_eot(engine_eot),
		.engine_empty_flag(engine_empty_flag), .decomp_control(decomp_control), .engine_run_enable(engine_run_enable));
	dhp_dma_model dhp_dma_model_i (.clk(clk), .strobe_mode(strobe_mode), .wide(wide), .data_out(data_out),
		.data_oe_n(data_oe_n), .data_in(data_in), .bus_output_enable_n(bus_output_enable_n),
		.strobe_wait_insert(strobe_wait_insert), .input_port_request_n(input_port_request_n),
		.input_port_ack_n(input_port_ack_n), .output_port_request_n(output_port_request_n),
		.output_port_ack_n(output_port_ack_n));
	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cycle ceiling cuts a hung run short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles >= 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		comparisons++;
		if (seen !== expected)
		begin
			miscompares++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, expected);
		end
	endtask : check
	// One register access; chip select is held only in the held-ready mode
	task automatic reg_access(input logic [5:0] idx, input logic is_read, input logic [7:0] wdat,
		output logic [7:0] rdat);
		int n;
		n = 0;
		rdat = 8'h00;
		@(negedge clk);
		chip_select_n = 1'b0;
		register_index_bus = idx;
		register_byte_in = wdat;
		direction = is_read ^ host_port_config[0];
		do
		begin
			@(negedge clk);
			if (!host_port_config[1])
				chip_select_n = 1'b1;
			n++;
		end while (access_ready_n !== 1'b0 && n < 16);
		check(32'(n == 2 || n == 3), 32'h1);
		check(register_byte_oe_n, !is_read);
		rdat = register_byte_out;
		@(negedge clk);
		chip_select_n = 1'b1;
		check(access_ready_n, !host_port_config[1]);
		repeat (2) @(negedge clk);
		check(access_ready_n, 1'b1);
	endtask : reg_access
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] x;
		reg_access(idx, 1'b0, d, x);
	endtask : wr
	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		reg_access(idx, 1'b1, 8'h00, x);
		check(x, exp);
	endtask : rd_chk
	task automatic set_cfg(input logic [7:0] v);
		wr(dhp_pkg::OFF_SYS_CFG1, v);
		strobe_mode = v[1:0];
		wide = v[2];
	endtask : set_cfg
	task automatic pulse_event(input logic eor, input logic eot);
		@(negedge clk);
		engine_eor = eor;
		engine_eot = eot;
		@(negedge clk);
		engine_eor = 1'b0;
		engine_eot = 1'b0;
	endtask : pulse_event
	// Engine accepts one input word after a stall
	task automatic drain_in(input logic [31:0] exp);
		int n;
		n = 0;
		while (engine_in_valid !== 1'b1 && n < 16)
		begin
			@(negedge clk);
			n++;
		end
		check(engine_in_data, exp);
		engine_in_ready = 1'b1;
		@(negedge clk);
		engine_in_ready = 1'b0;
	endtask : drain_in
	task automatic push_out(input logic [31:0] d);
		int n;
		n = 0;
		@(negedge clk);
		engine_out_valid = 1'b1;
		engine_out_data = d;
		while (engine_out_ready !== 1'b1 && n < 16)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		engine_out_valid = 1'b0;
		engine_out_data = ~d;
	endtask : push_out
	task automatic t_reset_values();
		rd_chk(6'h38, 8'h00);
		rd_chk(6'h3f, 8'h0f);
		rd_chk(dhp_pkg::OFF_DEC_CTRL, 8'h04);
		wr(6'h10, 8'h5a);
		rd_chk(6'h10, 8'h00);
		check(input_port_request_n, 1'b0);
		check(output_port_request_n, 1'b1);
	endtask : t_reset_values
	// Staged mode change moves across on end of record only while the stage-load bit is set
	task automatic t_staging();
		wr(6'h38, 8'h32);
		rd_chk(6'h38, 8'h32);
		pulse_event(1'b1, 1'b0);
		rd_chk(6'h38, 8'h32);
		wr(dhp_pkg::OFF_DEC_CTRL, 8'h80);
		pulse_event(1'b1, 1'b0);
		rd_chk(6'h38, 8'h00);
		check(decomp_control, 8'h36);
		check(engine_run_enable, 1'b0);
		wr(6'h3f, 8'h0e);
		rd_chk(6'h3f, 8'h0e);
		check(engine_run_enable, 1'b1);
		engine_empty_flag = 1'b0;
		rd_chk(dhp_pkg::OFF_DEC_CTRL, 8'h32);
		engine_empty_flag = 1'b1;
	endtask : t_staging
	// Interrupt through the inverted-direction, held-ready port mode
	task automatic t_interrupt();
		host_port_config = 2'h3;
		pulse_event(1'b0, 1'b1);
		rd_chk(dhp_pkg::OFF_INT_STAT, 8'h02);
		check(interrupt_n, 1'b1);
		wr(dhp_pkg::OFF_INT_MASK, 8'hfd);
		check(interrupt_n, 1'b0);
		wr(dhp_pkg::OFF_INT_STAT, 8'h02);
		check(interrupt_n, 1'b1);
		wr(dhp_pkg::OFF_INT_MASK, 8'hff);
		host_port_config = 2'h0;
	endtask : t_interrupt
	task automatic t_input_port();
		for (int m = 0; m < 4; m++)
		begin
			set_cfg({6'h01, 2'(m)});
			dhp_dma_model_i.send_word(32'hc0de0000 + m, (m == 1 || m == 2) ? 3 : 0);
			@(negedge clk);
			check(input_port_request_n, 1'b0);
			drain_in(32'hc0de0000 + m);
		end
		dhp_dma_model_i.send_word(32'h11111111, 0);
		dhp_dma_model_i.send_word(32'h22222222, 0);
		@(negedge clk);
		check(input_port_request_n, 1'b1);
		drain_in(32'h11111111);
		drain_in(32'h22222222);
		check(input_port_request_n, 1'b0);
		set_cfg(8'h00);
		dhp_dma_model_i.send_word(32'h1234abcd, 0);
		drain_in(32'h0000abcd);
	endtask : t_input_port
	task automatic t_output_port();
		set_cfg(8'h04);
		check(data_oe_n, 1'b1);
		push_out(32'h89abcdef);
		check(output_port_request_n, 1'b0);
		check(engine_out_ready, 1'b0);
		dhp_dma_model_i.take_word(w);
		check(w, 32'h89abcdef);
		check(engine_out_ready, 1'b1);
		check(dhp_dma_model_i.oe_seen, 1'b1);
		check(engine_in_valid, 1'b0);
		set_cfg(8'h00);
		push_out(32'h89abcdef);
		dhp_dma_model_i.take_word(w);
		check(w, 32'hffffcdef);
		check(output_port_request_n, 1'b1);
		check(dhp_dma_model_i.timed_out, 1'b0);
	endtask : t_output_port
	// Reset, then the scenarios in turn
	initial
	begin
		rst = 1'b1;
		chip_select_n = 1'b1;
		direction = 1'b0;
		host_port_config = 2'h0;
		register_index_bus = 6'h00;
		register_byte_in = 8'h00;
		engine_in_ready = 1'b0;
		engine_out_valid = 1'b0;
		engine_out_data = 32'h00000000;
		engine_eor = 1'b0;
		engine_eot = 1'b0;
		engine_empty_flag = 1'b1;
		strobe_mode = 2'h0;
		wide = 1'b0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		t_reset_values();
		t_staging();
		t_interrupt();
		t_input_port();
		t_output_port();
		end_of_test();
	end
endmodule : dhp_host_ports_test
